// ===== l2sb_params.svh
// offsets, field positions, reset values and counts of the sideband block
`ifndef L2SB_PARAMS_SVH
`define L2SB_PARAMS_SVH
`define AUX_OFS       8'h00
`define CFG_OFS       8'h04
`define STAT_OFS      8'h08
`define AUX_PFH_BIT   1
`define AUX_ZERO_BIT  3
`define AUX_EXCL_BIT  7
`define CFG_OPT_BIT   0
`define AUX_RESET     1'b0
`define CFG_RESET     1'b0
`define U_EARLY       8
`define U_ZERO        7
`define U_CLEAN       6
`define U_L1EV        5
`define U_HINT        5
`define LINE_LEN      8'h03
`define SINGLE_LEN    8'h00
`define MERGE_LSB     3
`define HINT_USER     7'h3F
`define PF_HITS       2'h2
`endif

// ===== l2sb_pkg.sv
// types shared by the sideband block
package l2sb_pkg;
   typedef enum logic [3:0] {
      ATTR_SO   = 4'h0,
      ATTR_DEV  = 4'h1,
      ATTR_NC   = 4'h3,
      ATTR_WT   = 4'h6,
      ATTR_WB   = 4'h7,
      ATTR_WBWA = 4'hF
   } attr_t;
   typedef enum logic [1:0] {
      K_PLAIN = 2'h0,
      K_EVICT = 2'h1,
      K_ZERO  = 2'h2
   } kind_t;
   typedef enum logic [2:0] {
      S_IDLE = 3'b001,
      S_AW   = 3'b010,
      S_AR   = 3'b100
   } state_t;

   function automatic logic is_cacheable(input logic [3:0] a);
      return (a == ATTR_WT) || (a == ATTR_WB) || (a == ATTR_WBWA);
   endfunction : is_cacheable

   function automatic logic is_mergeable(input logic [3:0] a);
      return (a != ATTR_SO) && (a != ATTR_DEV) && !is_cacheable(a);
   endfunction : is_mergeable
endpackage : l2sb_pkg

// ===== l2sb_side_if.sv
// attribute and prefetch signals between the block's modules
`timescale 1ns/1ns
interface l2sb_side_if;
   import l2sb_pkg::*;
   logic        write;
   attr_t       attr;
   logic        shared;
   logic        early_ok;
   logic        zero;
   logic        clean;
   logic        l1_evict;
   logic        priv_mode;
   logic        unpriv_store;
   logic [8:0]  awuser;
   logic [6:0]  aruser;
   logic        priv;
   logic        ld_valid;
   logic [31:0] ld_addr;
   logic        pf_enable;
   logic        hint_valid;
   logic [31:0] hint_addr;
   logic        hint_take;
   modport core (output write, attr, shared, early_ok, zero, clean, l1_evict, priv_mode,
                 unpriv_store, ld_valid, ld_addr, pf_enable, hint_take,
                 input awuser, aruser, priv, hint_valid, hint_addr);
   modport enc  (input write, attr, shared, early_ok, zero, clean, l1_evict, priv_mode,
                 unpriv_store, output awuser, aruser, priv);
   modport pf   (input ld_valid, ld_addr, pf_enable, hint_take, output hint_valid, hint_addr);
endinterface : l2sb_side_if

// ===== attr_encoder.sv
// user field and protection encoding of one request
`timescale 1ns/1ns
module attr_encoder (
   l2sb_side_if.enc io
);
   import l2sb_pkg::*;
   `include "l2sb_params.svh"

   always_comb begin
      io.awuser              = '0;
      io.awuser[`U_EARLY]    = io.early_ok;
      io.awuser[`U_ZERO]     = io.zero;
      io.awuser[`U_CLEAN]    = io.clean;
      io.awuser[`U_L1EV]     = io.l1_evict;
      io.awuser[4:1]         = io.attr;
      io.awuser[0]           = io.shared;
      io.aruser              = {2'b00, io.attr, io.shared};
      if (io.write && is_cacheable(io.attr)) begin
         io.priv = 1'b1;
      end else begin
         io.priv = io.priv_mode && !(io.write && io.unpriv_store);
      end
   end
endmodule : attr_encoder

// ===== stride_detect.sv
// regular-pattern watcher that raises prefetch hints
`timescale 1ns/1ns
`include "l2sb_params.svh"
module stride_detect #(
   parameter logic [1:0] HITS = `PF_HITS
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   l2sb_side_if.pf   io
);
   import l2sb_pkg::*;
   `include "l2sb_params.svh"

   typedef struct packed {
      logic [31:0] last;
      logic [31:0] stride;
      logic [1:0]  hits;
      logic        pend;
      logic [31:0] paddr;
   } pf_state_t;

   pf_state_t s;
   pf_state_t next_s;
   logic [31:0] delta;

   always_comb begin
      next_s = s;
      delta  = io.ld_addr - s.last;
      if (io.hint_take) begin
         next_s.pend = 1'b0;
      end
      if (io.ld_valid) begin
         next_s.last = io.ld_addr;
         if (delta == s.stride && delta != 32'h0) begin
            if (s.hits != HITS) begin
               next_s.hits = s.hits + 2'h1;
            end else begin
               next_s.pend  = 1'b1;
               next_s.paddr = io.ld_addr + s.stride;
            end
         end else begin
            next_s.stride = delta;
            next_s.hits   = 2'h0;
         end
      end
      if (!io.pf_enable) begin
         next_s.pend = 1'b0;
         next_s.hits = 2'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign io.hint_valid = s.pend;
   assign io.hint_addr  = s.paddr;
endmodule : stride_detect

// ===== l2_master_sideband.sv
// data-side write/read address sideband of the level-2 master port
// Summary of operation
// - write user bit 8 offers early response
// - write user bit 7 marks zero line
// - write user bit 6 marks clean eviction
// - write user bit 5 marks L1 eviction
// - user bits 4:1 attributes, bit 0 shared
// - exclusive mode needs both sides enabled
// - exclusive mode evicts clean victims too
// - optimized requests only if slaves support them
// - prefetch hint is read, user bit 5
// - aux bit 1 enables automatic hints, multiprocessor
// - early write responses always accepted
// - aux bit 3 enables single zero-line write
// - no merge for ordered/device; barriers split
// - cacheable writes always marked privileged
// - otherwise mode decides; unprivileged store user
`timescale 1ns/1ns
module l2_master_sideband #(
   parameter bit MP_CONFIG = 1'b1
) (
   // clock and reset
   input  wire logic          hclk,
   input  wire logic          hresetn,
   // register bus
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic [31:0]        hrdata,
   output logic               hreadyout,
   output logic               hresp,
   // core requests
   input  wire logic          req_valid,
   output logic               req_ready,
   input  wire logic          req_write,
   input  l2sb_pkg::kind_t    req_kind,
   input  wire logic [31:0]   req_addr,
   input  wire logic [63:0]   req_data,
   input  wire logic [7:0]    req_strb,
   input  l2sb_pkg::attr_t    req_attr,
   input  wire logic          req_shared,
   input  wire logic          req_dirty,
   input  wire logic          unprivileged_store_instr,
   input  wire logic          priv_mode,
   input  wire logic          barrier,
   input  wire logic          l2_excl_en,
   // write address and data
   output logic               awvalid,
   input  wire logic          awready,
   output logic [31:0]        awaddr,
   output logic [7:0]         awlen,
   output logic [8:0]         data_write_addr_user_field,
   output logic [2:0]         awprot,
   output logic [63:0]        wdata,
   output logic [7:0]         wstrb,
   // read address
   output logic               arvalid,
   input  wire logic          arready,
   output logic [31:0]        araddr,
   output logic [6:0]         aruser,
   output logic [2:0]         arprot,
   // write response
   input  wire logic          bvalid,
   output logic               bready
);
   import l2sb_pkg::*;
   `include "l2sb_params.svh"

   typedef struct packed {
      state_t      st;
      logic        pfh;
      logic        zero;
      logic        excl;
      logic        opt;
      logic        a_wr;
      logic [7:0]  a_addr;
      logic [31:0] hrdata;
      logic [31:0] awaddr;
      logic [7:0]  awlen;
      logic [8:0]  awuser;
      logic [2:0]  awprot;
      logic [63:0] wdata;
      logic [7:0]  wstrb;
      logic [31:0] araddr;
      logic [6:0]  aruser;
      logic [2:0]  arprot;
      logic        slot_v;
      logic        slot_seal;
      logic [31:0] slot_addr;
      logic [63:0] slot_data;
      logic [7:0]  slot_strb;
      logic [8:0]  slot_user;
      logic [2:0]  slot_prot;
      logic [3:0]  outst;
   } blk_state_t;

   blk_state_t  s;
   blk_state_t  next_s;
   logic        excl_eff;
   logic        zero_go;
   logic        hint_go;
   logic        merge_ok;
   logic        aw_hs;
   logic        acc;
   logic [2:0]  req_prot;
   l2sb_side_if io ();

   attr_encoder enc_i (
      .io (io.enc)
   );

   stride_detect pf_i (
      .hclk    (hclk),
      .hresetn (hresetn),
      .io      (io.pf)
   );

   function automatic logic [31:0] reg_read(input logic [7:0] a, input blk_state_t v);
      logic [31:0] r;
      r = '0;
      if (a == `AUX_OFS) begin
         r[`AUX_PFH_BIT]  = v.pfh;
         r[`AUX_ZERO_BIT] = v.zero;
         r[`AUX_EXCL_BIT] = v.excl;
      end else if (a == `CFG_OFS) begin
         r[`CFG_OPT_BIT] = v.opt;
      end else if (a == `STAT_OFS) begin
         r = {20'h0, v.outst, 4'h0, v.slot_v, v.st == S_AW, v.st == S_AR, excl_eff};
      end
      return r;
   endfunction : reg_read

   assign excl_eff        = s.excl && l2_excl_en;
   assign zero_go         = s.zero && s.opt;
   assign hint_go         = io.hint_valid && s.st == S_IDLE;
   assign aw_hs           = awvalid && awready;
   assign io.write        = req_write;
   assign io.attr         = req_attr;
   assign io.shared       = req_shared;
   assign io.early_ok     = req_write && s.opt;
   assign io.zero         = req_kind == K_ZERO && zero_go;
   assign io.clean        = req_kind == K_EVICT && !req_dirty;
   assign io.l1_evict     = req_kind == K_EVICT;
   assign io.priv_mode    = priv_mode;
   assign io.unpriv_store = unprivileged_store_instr;
   assign io.ld_valid     = req_valid && req_ready && !req_write && req_shared;
   assign io.ld_addr      = req_addr;
   assign io.pf_enable    = s.pfh && s.opt && MP_CONFIG;
   assign io.hint_take    = hint_go;
   assign req_prot        = {2'b00, io.priv};
   assign merge_ok        = s.slot_v && !s.slot_seal && req_write && req_kind == K_PLAIN
                            && is_mergeable(req_attr) && io.awuser == s.slot_user
                            && req_prot == s.slot_prot
                            && req_addr[31:`MERGE_LSB] == s.slot_addr[31:`MERGE_LSB];

   always_comb begin
      next_s = s;
      acc    = 1'b0;
      // register bus, address then data phase
      if (s.a_wr) begin
         if (s.a_addr == `AUX_OFS) begin
            next_s.pfh  = hwdata[`AUX_PFH_BIT];
            next_s.zero = hwdata[`AUX_ZERO_BIT];
            next_s.excl = hwdata[`AUX_EXCL_BIT];
         end else if (s.a_addr == `CFG_OFS) begin
            next_s.opt = hwdata[`CFG_OPT_BIT];
         end
      end
      next_s.a_wr = 1'b0;
      if (hsel && hready && htrans[1]) begin
         next_s.a_wr   = hwrite;
         next_s.a_addr = haddr[7:0];
         if (!hwrite) begin
            next_s.hrdata = reg_read(haddr[7:0], s);
         end
      end
      case (s.st)
         S_IDLE: begin
            if (hint_go) begin
               next_s.araddr = io.hint_addr;
               next_s.aruser = `HINT_USER;
               next_s.arprot = 3'h1;
               next_s.st     = S_AR;
            end else if (req_valid && !req_write) begin
               acc           = 1'b1;
               next_s.araddr = req_addr;
               next_s.aruser = io.aruser;
               next_s.arprot = req_prot;
               next_s.st     = S_AR;
            end else if (req_valid && req_kind == K_EVICT && !req_dirty && !excl_eff) begin
               acc = 1'b1;
            end else if (req_valid && merge_ok) begin
               acc = 1'b1;
               for (int i = 0; i < 8; i++) begin
                  if (req_strb[i]) begin
                     next_s.slot_data[8*i +: 8] = req_data[8*i +: 8];
                  end
               end
               next_s.slot_strb = s.slot_strb | req_strb;
            end else if (s.slot_v) begin
               next_s.awaddr = {s.slot_addr[31:`MERGE_LSB], 3'h0};
               next_s.awlen  = `SINGLE_LEN;
               next_s.awuser = s.slot_user;
               next_s.awprot = s.slot_prot;
               next_s.wdata  = s.slot_data;
               next_s.wstrb  = s.slot_strb;
               next_s.slot_v = 1'b0;
               next_s.st     = S_AW;
            end else if (req_valid && req_kind == K_PLAIN && is_mergeable(req_attr)) begin
               acc              = 1'b1;
               next_s.slot_v    = 1'b1;
               next_s.slot_seal = 1'b0;
               next_s.slot_addr = req_addr;
               next_s.slot_data = req_data;
               next_s.slot_strb = req_strb;
               next_s.slot_user = io.awuser;
               next_s.slot_prot = req_prot;
            end else if (req_valid) begin
               acc           = 1'b1;
               next_s.awaddr = req_addr;
               next_s.awuser = io.awuser;
               next_s.awprot = req_prot;
               next_s.wdata  = req_kind == K_ZERO ? 64'h0 : req_data;
               next_s.wstrb  = req_kind == K_PLAIN ? req_strb : 8'hFF;
               if (req_kind == K_EVICT || (req_kind == K_ZERO && !zero_go)) begin
                  next_s.awlen = `LINE_LEN;
               end else begin
                  next_s.awlen = `SINGLE_LEN;
               end
               next_s.st = S_AW;
            end
         end
         S_AW: begin
            if (awready) begin
               next_s.st = S_IDLE;
            end
         end
         S_AR: begin
            if (arready) begin
               next_s.st = S_IDLE;
            end
         end
         default: begin
            next_s.st = S_IDLE;
         end
      endcase
      if (barrier) begin
         next_s.slot_seal = 1'b1;
      end
      if (aw_hs && !bvalid) begin
         next_s.outst = s.outst + 4'h1;
      end else if (bvalid && !aw_hs && s.outst != 4'h0) begin
         next_s.outst = s.outst - 4'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s      <= '0;
         s.st   <= S_IDLE;
         s.pfh  <= `AUX_RESET;
         s.zero <= `AUX_RESET;
         s.excl <= `AUX_RESET;
         s.opt  <= `CFG_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign req_ready                  = acc;
   assign hrdata                     = s.hrdata;
   assign hreadyout                  = 1'b1;
   assign hresp                      = 1'b0;
   assign awvalid                    = s.st == S_AW;
   assign awaddr                     = s.awaddr;
   assign awlen                      = s.awlen;
   assign data_write_addr_user_field = s.awuser;
   assign awprot                     = s.awprot;
   assign wdata                      = s.wdata;
   assign wstrb                      = s.wstrb;
   assign arvalid                    = s.st == S_AR;
   assign araddr                     = s.araddr;
   assign aruser                     = s.aruser;
   assign arprot                     = s.arprot;
   assign bready                     = 1'b1;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_aw_wait;
      awvalid && !awready;
   endsequence
   sequence s_evict_in(logic dirty);
      req_valid && req_ready && req_write && req_kind == K_EVICT && req_dirty == dirty;
   endsequence

   property p_early;
      awvalid |-> data_write_addr_user_field[`U_EARLY] == s.opt;
   endproperty
   a_early: assert property (p_early) else $error("early response bit wrong");
   property p_zero;
      awvalid && data_write_addr_user_field[`U_ZERO] |-> zero_go && awlen == `SINGLE_LEN
         && wdata == 64'h0;
   endproperty
   a_zero: assert property (p_zero) else $error("zero line marking wrong");
   property p_clean;
      s_evict_in(1'b0) ##0 excl_eff |=> awvalid && data_write_addr_user_field[`U_CLEAN]
         && awlen == `LINE_LEN;
   endproperty
   a_clean: assert property (p_clean) else $error("clean eviction unmarked");
   property p_l1ev;
      s_evict_in(1'b1) |=> awvalid && data_write_addr_user_field[`U_L1EV];
   endproperty
   a_l1ev: assert property (p_l1ev) else $error("dirty eviction missing");
   property p_attr;
      awvalid |-> data_write_addr_user_field[4:1] inside {4'h0, 4'h1, 4'h3, 4'h6, 4'h7, 4'hF};
   endproperty
   a_attr: assert property (p_attr) else $error("illegal inner attribute");
   property p_drop;
      s_evict_in(1'b0) ##0 !excl_eff |=> !awvalid;
   endproperty
   a_drop: assert property (p_drop) else $error("clean victim evicted outside exclusive");
   property p_excl;
      awvalid && data_write_addr_user_field[`U_CLEAN] |-> excl_eff
         && data_write_addr_user_field[`U_L1EV] && awlen == `LINE_LEN;
   endproperty
   a_excl: assert property (p_excl) else $error("clean victim issued without exclusive");
   property p_hint;
      arvalid && aruser[`U_HINT] |-> s.pfh && s.opt && MP_CONFIG;
   endproperty
   a_hint: assert property (p_hint) else $error("hint issued while disabled");
   property p_bresp;
      bvalid && !aw_hs && s.outst != 4'h0 |=> s.outst == $past(s.outst) - 4'h1;
   endproperty
   a_bresp: assert property (p_bresp) else $error("write response not counted");
   property p_nomerge;
      s.slot_v |-> s.slot_user[4:1] != ATTR_SO && s.slot_user[4:1] != ATTR_DEV;
   endproperty
   a_nomerge: assert property (p_nomerge) else $error("ordered write in merge slot");
   property p_priv;
      awvalid && is_cacheable(data_write_addr_user_field[4:1]) |-> awprot[0];
   endproperty
   a_priv: assert property (p_priv) else $error("cacheable write not privileged");
   property p_rdprot;
      req_valid && req_ready && !req_write |=> arvalid && arprot[0] == $past(priv_mode);
   endproperty
   a_rdprot: assert property (p_rdprot) else $error("read protection wrong");
   property p_hold;
      s_aw_wait |=> awvalid && $stable(data_write_addr_user_field) && $stable(awaddr);
   endproperty
   a_hold: assert property (p_hold) else $error("write address changed while waiting");
endmodule : l2_master_sideband

// ===== axi_l2_slave.sv
// far-side cache controller model of the address and response channels
`timescale 1ns/1ns
module axi_l2_slave (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // address channels
   input  wire logic       awvalid,
   input  wire logic       arvalid,
   input  wire logic [8:0] awuser,
   input  wire logic [1:0] stall,
   output logic            awready,
   output logic            arready,
   // write response
   output logic            bvalid
);
   logic [1:0] late;
   logic       l2_dirty;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         awready <= 1'b0;
         arready <= 1'b0;
         bvalid  <= 1'b0;
         late    <= 2'h0;
         l2_dirty <= 1'b0;
      end else begin
         awready <= !stall[0];
         arready <= !stall[1] && !(arvalid && l2_dirty);
         // dirty line written back before the linefill
         if (arvalid && l2_dirty)
            l2_dirty <= 1'b0;
         bvalid  <= late == 2'h1;
         if (late != 2'h0)
            late <= late - 2'h1;
         if (awvalid && awready) begin
            l2_dirty <= 1'b1;
            // early answer once address taken, else late
            if (awuser[8])
               bvalid <= 1'b1;
            else
               late <= 2'h3;
         end
      end
   end
endmodule : axi_l2_slave

// ===== l2_master_sideband_tb.sv
// self-checking bench of the level-2 master sideband block
`timescale 1ns/1ns
`include "l2sb_params.svh"
module l2_master_sideband_tb;
   import l2sb_pkg::*;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0;
   logic        req_write = 1'b0, req_shared = 1'b0, req_dirty = 1'b0, us = 1'b0;
   logic        priv_mode = 1'b0, barrier = 1'b0, l2_excl_en = 1'b0, hold = 1'b0;
   logic        opt = 1'b0, zon = 1'b0;
   logic [1:0]  htrans = 2'h0, stall = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, req_addr = 32'h0, seed = 32'h5C43;
   logic [31:0] hrdata, araddr, rd, hint_addr, awaddr, cap_a, cap_ra;
   logic [63:0] wdata, cap_d, req_data = 64'h0;
   logic [7:0]  req_strb = 8'h00, awlen, wstrb, cap_len, cap_strb;
   logic [8:0]  awu, cap_u, hold_u;
   logic [6:0]  aruser, cap_ar;
   logic [2:0]  awprot, arprot, cap_p, cap_ap;
   kind_t       req_kind = K_PLAIN;
   attr_t       req_attr = ATTR_SO;
   logic        hready, hreadyout, req_ready, awvalid, awready, arvalid, arready, bvalid, bready;
   logic        hresp;
   int          num_errors = 0, cmp_count = 0, aw_cnt = 0, ar_cnt = 0, hint_cnt = 0, n, c;
   attr_t       codes [6] = '{ATTR_SO, ATTR_DEV, ATTR_NC, ATTR_WT, ATTR_WB, ATTR_WBWA};
   assign hready = hreadyout;
   always #20 hclk = ~hclk;
   l2_master_sideband dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .req_valid(req_valid), .req_ready(req_ready),
      .req_write(req_write), .req_kind(req_kind), .req_addr(req_addr), .req_data(req_data),
      .req_strb(req_strb), .req_attr(req_attr), .req_shared(req_shared), .req_dirty(req_dirty),
      .unprivileged_store_instr(us), .priv_mode(priv_mode), .barrier(barrier),
      .l2_excl_en(l2_excl_en), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awlen(awlen), .data_write_addr_user_field(awu), .awprot(awprot), .wdata(wdata),
      .wstrb(wstrb), .arvalid(arvalid), .arready(arready), .araddr(araddr), .aruser(aruser),
      .arprot(arprot), .bvalid(bvalid), .bready(bready));
   axi_l2_slave slave_u (.hclk(hclk), .hresetn(hresetn), .awvalid(awvalid), .awuser(awu),
      .arvalid(arvalid), .stall(stall), .awready(awready), .arready(arready), .bvalid(bvalid));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [8:0] eu(input kind_t k, attr_t a, logic sh, logic dirty);
      return {opt, (k == K_ZERO) && zon && opt, (k == K_EVICT) && !dirty, k == K_EVICT, a, sh};
   endfunction : eu
   function automatic logic ep(input logic w, attr_t a);
      return (w && (a inside {ATTR_WT, ATTR_WB, ATTR_WBWA})) || (priv_mode && !(w && us));
   endfunction : ep
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic print_verdict;
      if (num_errors == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
      chk(hresp, 1'b0);
   endtask : ahb
   task automatic req(input logic w, kind_t k, attr_t a, logic [31:0] ad, logic [7:0] s,
                      input logic b, input logic drop);
      req_valid <= 1'b1;
      req_write <= w;
      req_kind <= k;
      req_attr <= a;
      req_addr <= ad;
      req_strb <= s;
      req_data <= {seed, ~seed};
      barrier <= b;
      do @(posedge hclk); while (req_ready !== 1'b1);
      if (drop)
         req_valid <= 1'b0;
   endtask : req
   task automatic wait_cnt(ref int cnt, input int t);
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (cnt < t && n < 80);
      chk(cnt, t);
   endtask : wait_cnt
   task automatic op(input logic w, kind_t k, attr_t a, logic [31:0] ad);
      c = w ? aw_cnt : ar_cnt;
      req(w, k, a, ad, 8'hFF, 1'b0, 1'b1);
      if (w) begin
         wait_cnt(aw_cnt, c + 1);
         chk(cap_u, eu(k, a, req_shared, req_dirty));
         chk(cap_p[0], ep(1'b1, a));
         chk(cap_a, ad);
         chk(cap_d, (k == K_ZERO) ? 64'h0 : req_data);
         chk(cap_len, (k == K_PLAIN || (k == K_ZERO && zon && opt)) ? `SINGLE_LEN
             : `LINE_LEN);
      end else begin
         wait_cnt(ar_cnt, c + 1);
         chk(cap_ar, {2'b00, a, req_shared});
         chk(cap_ap[0], ep(1'b0, a));
         chk(cap_ra, ad);
      end
   endtask : op
   always @(posedge hclk) begin
      seed <= lfsr(seed);
      stall <= seed[1:0];
      if (hold)
         chk({awvalid, awu}, {1'b1, hold_u});
      hold = awvalid && !awready;
      hold_u = awu;
      if (bvalid)
         chk(bready, 1'b1);
      if (awvalid && awready) begin
         aw_cnt++;
         {cap_u, cap_len, cap_strb, cap_p} = {awu, awlen, wstrb, awprot};
         {cap_a, cap_d} = {awaddr, wdata};
      end
      if (arvalid && arready) begin
         ar_cnt++;
         {cap_ar, cap_ap} = {aruser, arprot};
         cap_ra = araddr;
         if (aruser[5]) begin
            hint_cnt++;
            hint_addr = araddr;
         end
      end
   end
   initial begin
      #400000;
      num_errors++;
      print_verdict();
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b1, 32'h0C, 32'hFFFFFFFF);
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, i * 4, 32'h0);
         chk(rd, 32'h0);
      end
      ahb(1'b1, `CFG_OFS, 32'h1);
      opt = 1'b1;
      for (int i = 0; i < 24; i++) begin
         req_shared <= seed[2];
         priv_mode <= seed[3];
         us <= seed[4];
         op(i[0], K_PLAIN, codes[(i / 2) % 6], {seed[31:8], i[4:0], 3'h0});
      end
      for (int j = 0; j < 3; j++) begin
         ahb(1'b1, `CFG_OFS, 32'(j != 0));
         ahb(1'b1, `AUX_OFS, 32'(j != 2) << `AUX_ZERO_BIT);
         {opt, zon} = {j != 0, j != 2};
         op(1'b1, K_ZERO, ATTR_WBWA, 32'h800);
         chk(cap_len, (j == 1) ? `SINGLE_LEN : `LINE_LEN);
      end
      req_dirty <= 1'b1;
      op(1'b1, K_EVICT, ATTR_WBWA, 32'h1000);
      for (int j = 0; j < 4; j++) begin
         ahb(1'b1, `AUX_OFS, 32'(j[0]) << `AUX_EXCL_BIT);
         l2_excl_en <= j[1];
         req_dirty <= 1'b0;
         if (j == 3)
            op(1'b1, K_EVICT, ATTR_WBWA, 32'h1040);
         else begin
            c = aw_cnt;
            req(1'b1, K_EVICT, ATTR_WBWA, 32'h1040, 8'hFF, 1'b0, 1'b1);
            repeat (20) @(posedge hclk);
            chk(aw_cnt, c);
         end
      end
      {req_shared, priv_mode, us} <= 3'b000;
      for (int j = 0; j < 3; j++) begin
         c = aw_cnt;
         req(1'b1, K_PLAIN, j == 1 ? ATTR_DEV : ATTR_NC, 32'h2000, 8'h0F, j == 2, 1'b0);
         req(1'b1, K_PLAIN, j == 1 ? ATTR_DEV : ATTR_NC, 32'h2000, 8'hF0, 1'b0, 1'b1);
         wait_cnt(aw_cnt, c + ((j == 0) ? 1 : 2));
         repeat (10) @(posedge hclk);
         chk({aw_cnt[7:0], cap_strb}, {8'(c + ((j == 0) ? 1 : 2)), (j == 0) ? 8'hFF : 8'hF0});
      end
      ahb(1'b1, `AUX_OFS, 32'h1 << `AUX_PFH_BIT);
      req_shared <= 1'b1;
      for (int k = 0; k < 5; k++)
         op(1'b0, K_PLAIN, ATTR_WBWA, 32'h4000 + k * 32'h40);
      wait_cnt(hint_cnt, 1);
      chk({cap_ar, cap_ap[0], hint_addr}, {`HINT_USER, 1'b1, 32'h4140});
      print_verdict();
   end
endmodule : l2_master_sideband_tb
